// ==== core/plc_defines.svh ====
// constants of the macrocell logic array control block: register offsets,
// field positions, reset values and timing; assumes a 32-bit word-aligned register port
// Notes on behaviour
// - After power-up reset every macrocell register is cleared low without any clock edge.
// - A registered macrocell drives the inverse of its register, so it reads high after reset.
// - Each macrocell register can be preloaded high or low on its own for test.
// - Once the security fuse is set, array readback and preload are refused at once.
// - A 64-bit signature of eight bytes stays readable and writable even when secured.
// - Each macrocell is registered, combinatorial I/O, combinatorial output or input.
// - Exactly one of registered, complex or simple mode governs every macrocell.
// - An undriven input or I/O pin is pulled weakly high but can be overdriven.
// - A registered cell sums eight terms, captures on the clock pin, drives while OE is on.
// - A combinatorial cell in complex or registered mode sums seven terms; one term is OE except for output or input cells.
// - In simple mode cells sum eight terms and the two centre cells are always enabled.
// - A cell configured as input keeps its output driver disabled, except a centre cell in simple mode.
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH
`define OFS_MODE 8'h00
`define OFS_CELL_CFG 8'h04
`define OFS_SECURE 8'h08
`define OFS_PT_INDEX 8'h0C
`define OFS_PT_DATA 8'h10
`define OFS_PRELOAD 8'h14
`define OFS_STATUS 8'h18
`define OFS_SIG_BASE 8'h20
`define SIG_SEL_HI 7
`define SIG_SEL_LO 5
`define SIG_SEL_CODE 3'h1
`define STAT_SECURE 8
`define STAT_BUSY 9
`define STAT_REFUSED 10
`define PRE_VAL_LO 8
`define CENTRE_A 3
`define CENTRE_B 4
`define PUR_INTERVAL_NS 1000
`define CLK_PERIOD_NS 8
`define PT_ERASED 32'hFFFFFFFF
`endif

// ==== core/plc_pkg.sv ====
// types shared by the macrocell logic array control block
package plc_pkg;
   typedef enum logic [1:0] {
      MODE_REG = 2'b00,
      MODE_COMPLEX = 2'b01,
      MODE_SIMPLE = 2'b10
   } mode_e;
   typedef enum logic [1:0] {
      CELL_REG = 2'b00,
      CELL_COMB_IO = 2'b01,
      CELL_COMB_OUT = 2'b10,
      CELL_INPUT = 2'b11
   } cell_cfg_e;
   // one product term: literals taken true and literals taken complemented
   typedef struct packed {
      logic [15:0] lit_comp;
      logic [15:0] lit_true;
   } pt_entry_s;
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe;
   } pin_out_s;
endpackage

// ==== core/product_term_sum.sv ====
// evaluates the product terms of one macrocell against the literal vector
// assumes entries come straight from the configuration array
`timescale 1ns/100ps
module product_term_sum #(
   parameter int N_TERMS = 8
) (
   input wire logic [15:0] lits,
   input wire plc_pkg::pt_entry_s [N_TERMS-1:0] terms,
   output logic [N_TERMS-1:0] pterm
);
   // a literal selected both true and complemented kills the term (erased state)
   function automatic logic eval_term(input plc_pkg::pt_entry_s e, input logic [15:0] l);
      eval_term = &((~e.lit_true | l) & (~e.lit_comp | ~l));
   endfunction
   always_comb begin
      for (int t = 0; t < N_TERMS; t++) begin
         pterm[t] = eval_term(terms[t], lits);
      end
   end
endmodule // product_term_sum

// ==== core/macrocell_logic_array_control.sv ====
// eight-macrocell programmable logic array with mode control, preload,
// security fuse and user signature; rst_n stands for power-up reset,
// the clock and output-enable pins are sampled on clk_sys
`timescale 1ns/100ps
`include "plc_defines.svh"
module macrocell_logic_array_control (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [7:0] in_pin,
   input wire logic [7:0] in_driven,
   input wire logic clk_pin,
   input wire logic oe_pin_n,
   input wire logic [7:0] io_in,
   input wire logic [7:0] io_driven,
   output plc_pkg::pin_out_s io_pins
);
   localparam int PUR_CYCLES = `PUR_INTERVAL_NS / `CLK_PERIOD_NS;
   localparam logic [7:0] PUR_LOAD = 8'(PUR_CYCLES);

   plc_pkg::mode_e mode;
   plc_pkg::cell_cfg_e cell_cfg [8];
   logic secure;
   logic [5:0] pt_idx;
   plc_pkg::pt_entry_s pt_mem [64];
   logic [7:0] sig [8];
   logic [7:0] q;
   logic [7:0] pur_cnt;
   logic refused;
   logic clk_pin_d;
   logic [31:0] next_rdata;
   plc_pkg::pin_out_s next_pins;
   logic [7:0] next_q;
   plc_pkg::pt_entry_s [7:0] cell_terms [8];
   logic [7:0] pt_all [8];
   logic [7:0] fb;

   wire wr_mode = reg_wr && reg_addr == `OFS_MODE;
   wire wr_cfg = reg_wr && reg_addr == `OFS_CELL_CFG;
   wire wr_secure = reg_wr && reg_addr == `OFS_SECURE && reg_wdata[0];
   wire wr_idx = reg_wr && reg_addr == `OFS_PT_INDEX;
   wire wr_pt = reg_wr && reg_addr == `OFS_PT_DATA;
   wire wr_pre = reg_wr && reg_addr == `OFS_PRELOAD;
   wire wr_stat = reg_wr && reg_addr == `OFS_STATUS;
   wire sig_hit = reg_addr[`SIG_SEL_HI:`SIG_SEL_LO] == `SIG_SEL_CODE;
   wire [2:0] sig_sel = reg_addr[4:2];
   wire wr_sig = reg_wr && sig_hit;
   wire rd_pt = reg_rd && reg_addr == `OFS_PT_DATA;
   wire pre_ok = wr_pre && !secure;
   wire refuse_ev = (wr_pre || rd_pt) && secure;
   wire busy = pur_cnt != 8'h00;
   wire clk_edge = clk_pin && !clk_pin_d;
   wire [7:0] in_eff = in_pin | ~in_driven;
   wire [7:0] pin_eff = (io_pins.oe & io_pins.level) | (~io_pins.oe & (io_in | ~io_driven));
   wire [15:0] lits = {fb, in_eff};
   wire [7:0] pre_mask = reg_wdata[7:0];
   wire [7:0] pre_val = reg_wdata[`PRE_VAL_LO +: 8];
   wire [31:0] stat_word = {21'h000000, refused, busy, secure, q};
   wire [15:0] cfg_word = {cell_cfg[7], cell_cfg[6], cell_cfg[5], cell_cfg[4],
                           cell_cfg[3], cell_cfg[2], cell_cfg[1], cell_cfg[0]};
   wire [31:0] rd_word =
      (reg_addr == `OFS_MODE) ? {30'h00000000, mode} :
      (reg_addr == `OFS_CELL_CFG) ? {16'h0000, cfg_word} :
      (reg_addr == `OFS_SECURE) ? {31'h00000000, secure} :
      (reg_addr == `OFS_PT_INDEX) ? {26'h0000000, pt_idx} :
      (reg_addr == `OFS_PT_DATA) ? (secure ? 32'h00000000 : pt_mem[pt_idx]) :
      (reg_addr == `OFS_STATUS) ? stat_word :
      sig_hit ? {24'h000000, sig[sig_sel]} : 32'h00000000;

   function automatic logic is_centre(input int i);
      is_centre = (i == `CENTRE_A) || (i == `CENTRE_B);
   endfunction

   // feedback: register for registered cells in registered mode, pin otherwise; centre cells none in simple
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (mode == plc_pkg::MODE_REG && cell_cfg[i] == plc_pkg::CELL_REG) begin
            fb[i] = q[i];
         end else if (mode == plc_pkg::MODE_SIMPLE && is_centre(i)) begin
            fb[i] = 1'b0;
         end else begin
            fb[i] = pin_eff[i];
         end
         for (int t = 0; t < 8; t++) begin
            cell_terms[i][t] = pt_mem[i * 8 + t];
         end
      end
   end

   for (genvar g = 0; g < 8; g++) begin : g_cell
      product_term_sum #(.N_TERMS(8)) u_sum (
         .lits(lits),
         .terms(cell_terms[g]),
         .pterm(pt_all[g])
      );
   end

   // per-cell output level and enable by mode and cell configuration
   always_comb begin
      next_pins = '0;
      next_q = q;
      for (int i = 0; i < 8; i++) begin
         unique case (mode)
            plc_pkg::MODE_REG, plc_pkg::MODE_COMPLEX: begin
               if (mode == plc_pkg::MODE_REG && cell_cfg[i] == plc_pkg::CELL_REG) begin
                  next_pins.level[i] = ~q[i];
                  next_pins.oe[i] = ~oe_pin_n;
                  if (clk_edge && !busy) begin
                     next_q[i] = |pt_all[i];
                  end
               end else begin
                  next_pins.level[i] = |pt_all[i][6:0];
                  unique case (cell_cfg[i])
                     plc_pkg::CELL_COMB_OUT: next_pins.oe[i] = 1'b1;
                     plc_pkg::CELL_INPUT: next_pins.oe[i] = 1'b0;
                     plc_pkg::CELL_REG, plc_pkg::CELL_COMB_IO: next_pins.oe[i] = pt_all[i][7];
                  endcase
               end
            end
            plc_pkg::MODE_SIMPLE: begin
               next_pins.level[i] = |pt_all[i];
               next_pins.oe[i] = is_centre(i) || cell_cfg[i] != plc_pkg::CELL_INPUT;
            end
            default: begin
               next_pins.level[i] = 1'b0;
               next_pins.oe[i] = 1'b0;
            end
         endcase
      end
      if (pre_ok) begin
         next_q = (q & ~pre_mask) | (pre_val & pre_mask);
      end
   end

   assign next_rdata = reg_rd ? rd_word : 32'h00000000;

   // power-up clear of registers, then hold off capture for the reset interval
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= 8'h00;
         pur_cnt <= PUR_LOAD;
         io_pins <= '0;
         reg_rdata <= 32'h00000000;
         clk_pin_d <= 1'b0;
      end else begin
         q <= next_q;
         pur_cnt <= busy ? pur_cnt - 8'h01 : pur_cnt;
         io_pins <= next_pins;
         reg_rdata <= next_rdata;
         clk_pin_d <= clk_pin;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode <= plc_pkg::MODE_REG;
         secure <= 1'b0;
         pt_idx <= 6'h00;
         refused <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode <= plc_pkg::mode_e'(reg_wdata[1:0]);
         end
         if (wr_secure) begin
            secure <= 1'b1;
         end
         if (wr_idx) begin
            pt_idx <= reg_wdata[5:0];
         end
         refused <= refuse_ev || (refused && !(wr_stat && reg_wdata[`STAT_REFUSED]));
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) begin
            cell_cfg[i] <= plc_pkg::CELL_INPUT;
            sig[i] <= 8'h00;
         end
         for (int k = 0; k < 64; k++) begin
            pt_mem[k] <= `PT_ERASED;
         end
      end else begin
         if (wr_cfg) begin
            for (int i = 0; i < 8; i++) begin
               cell_cfg[i] <= plc_pkg::cell_cfg_e'(reg_wdata[2 * i +: 2]);
            end
         end
         if (wr_pt) begin
            pt_mem[pt_idx] <= reg_wdata;
         end
         if (wr_sig) begin
            sig[sig_sel] <= reg_wdata[7:0];
         end
      end
   end

   property p_por_clear;
      @(posedge clk_sys) $rose(rst_n) |-> q == 8'h00 && io_pins.level == 8'h00;
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("registers not clear");

   property p_hold_busy;
      @(posedge clk_sys) disable iff (!rst_n) busy && !pre_ok |=> $stable(q);
   endproperty
   a_hold_busy: assert property (p_hold_busy) else $error("capture during reset");

   property p_inverted;
      @(posedge clk_sys) disable iff (!rst_n)
         mode == plc_pkg::MODE_REG && cell_cfg[0] == plc_pkg::CELL_REG
         |=> io_pins.level[0] == !$past(q[0]);
   endproperty
   a_inverted: assert property (p_inverted) else $error("output not inverted");

   property p_preload;
      @(posedge clk_sys) disable iff (!rst_n)
         pre_ok |=> (q & $past(pre_mask)) == ($past(pre_val) & $past(pre_mask));
   endproperty
   a_preload: assert property (p_preload) else $error("preload lost");

   property p_sec_pre;
      @(posedge clk_sys) disable iff (!rst_n) wr_pre && secure && !clk_edge |=> $stable(q);
   endproperty
   a_sec_pre: assert property (p_sec_pre) else $error("preload when secured");

   property p_sec_rd;
      @(posedge clk_sys) disable iff (!rst_n) rd_pt && secure |=> reg_rdata == 32'h00000000;
   endproperty
   a_sec_rd: assert property (p_sec_rd) else $error("readback when secured");

   property p_sig;
      @(posedge clk_sys) disable iff (!rst_n)
         reg_wr && reg_addr == `OFS_SIG_BASE ##2 reg_rd && reg_addr == `OFS_SIG_BASE
         |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 3);
   endproperty
   a_sig: assert property (p_sig) else $error("signature mismatch");

   property p_input_off;
      @(posedge clk_sys) disable iff (!rst_n)
         cell_cfg[1] == plc_pkg::CELL_INPUT |=> !io_pins.oe[1];
   endproperty
   a_input_off: assert property (p_input_off) else $error("input cell drives");

   property p_centre;
      @(posedge clk_sys) disable iff (!rst_n)
         mode == plc_pkg::MODE_SIMPLE |=> io_pins.oe[`CENTRE_A] && io_pins.oe[`CENTRE_B];
   endproperty
   a_centre: assert property (p_centre) else $error("centre cell disabled");

   property p_oe_pin;
      @(posedge clk_sys) disable iff (!rst_n)
         mode == plc_pkg::MODE_REG && cell_cfg[0] == plc_pkg::CELL_REG && oe_pin_n
         |=> !io_pins.oe[0];
   endproperty
   a_oe_pin: assert property (p_oe_pin) else $error("oe pin ignored");

   property p_pt_oe;
      @(posedge clk_sys) disable iff (!rst_n)
         mode == plc_pkg::MODE_COMPLEX && cell_cfg[2] == plc_pkg::CELL_COMB_IO
         |=> io_pins.oe[2] == $past(pt_all[2][7]);
   endproperty
   a_pt_oe: assert property (p_pt_oe) else $error("term oe wrong");

   c_capture: cover property (@(posedge clk_sys) disable iff (!rst_n)
      clk_edge && !busy && mode == plc_pkg::MODE_REG);
   c_refuse: cover property (@(posedge clk_sys) disable iff (!rst_n) refuse_ev);
   c_simple: cover property (@(posedge clk_sys) disable iff (!rst_n)
      mode == plc_pkg::MODE_SIMPLE ##1 wr_sig);
endmodule // macrocell_logic_array_control

// ==== tb/board_model.sv ====
// board-side model of the logic around the array: inputs, clock pin and output-enable pin
// assumes clk_sys at 8 ns and that the testbench calls its tasks from one process
`timescale 1ns/100ps
module board_model #(
   parameter int PUR_CYCLES = 125
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   output logic [7:0] in_pin,
   output logic [7:0] in_driven,
   output logic clk_pin,
   output logic oe_pin_n,
   output logic [7:0] io_in,
   output logic [7:0] io_driven
);
   logic [7:0] in_val = 8'h00;
   logic [7:0] io_val = 8'h00;
   logic [7:0] io_noise = 8'h00;
   int quiet = 0;
   // an undriven line shows the inverse of the last value, so only the pull-up gives a 1
   assign in_pin = (in_driven & in_val) | (~in_driven & ~in_val);
   // undriven macrocell pins carry a pattern that changes every cycle
   assign io_in = (io_driven & io_val) | (~io_driven & io_noise);
   initial begin
      in_driven = 8'h00;
      clk_pin = 1'b0;
      oe_pin_n = 1'b1;
      io_driven = 8'h00;
   end
   always @(posedge clk_sys) begin
      io_noise <= ~io_noise;
   end
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         quiet <= 0;
      end else if (quiet < PUR_CYCLES) begin
         quiet <= quiet + 1;
      end
   end
   task set_in(input logic [7:0] v, input logic [7:0] drv, input logic oe_n);
      @(posedge clk_sys);
      in_val <= v;
      in_driven <= drv;
      oe_pin_n <= oe_n;
   endtask
   task set_io(input logic [7:0] v, input logic [7:0] drv);
      @(posedge clk_sys);
      io_val <= v;
      io_driven <= drv;
   endtask
   // the clock stays still through the reset interval and rises only after inputs settled
   task pulse_clock;
      while (quiet < PUR_CYCLES) @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      clk_pin <= 1'b1;
      repeat (2) @(posedge clk_sys);
      clk_pin <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule // board_model

// ==== tb/testbench.sv ====
// self-checking bench for the macrocell logic array control block
// assumes the register map of plc_defines.svh and the board model beside it
`timescale 1ns/100ps
`include "plc_defines.svh"
module testbench;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } row_s;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [7:0] in_pin, in_driven, io_in, io_driven;
   logic clk_pin, oe_pin_n;
   plc_pkg::pin_out_s io_pins;
   logic [31:0] rdat;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   row_s rows [7] = '{
      '{1'b1, `OFS_SIG_BASE, 32'h000000A5, 32'h000000A5},
      '{1'b1, 8'h3C, 32'h0000003C, 32'h0000003C},
      '{1'b1, `OFS_MODE, 32'h00000002, 32'h00000002},
      '{1'b1, `OFS_MODE, 32'h00000001, 32'h00000001},
      '{1'b1, `OFS_CELL_CFG, 32'h0000FFFF, 32'h0000FFFF},
      '{1'b1, 8'hF0, 32'h000000FF, 32'h00000000},
      '{1'b1, `OFS_MODE, 32'h00000000, 32'h00000000}
   };
   always #4 clk_sys = ~clk_sys;
   macrocell_logic_array_control macrocell_logic_array_control_i (.clk_sys(clk_sys),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_pin(in_pin), .in_driven(in_driven),
      .clk_pin(clk_pin), .oe_pin_n(oe_pin_n), .io_in(io_in), .io_driven(io_driven),
      .io_pins(io_pins));
   board_model board_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .in_pin(in_pin),
      .in_driven(in_driven), .clk_pin(clk_pin), .oe_pin_n(oe_pin_n), .io_in(io_in),
      .io_driven(io_driven));
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t pins got %h exp %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task do_reset;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      chk_byte(io_pins.oe | io_pins.level, 8'h00);
      chk_word(reg_rdata, 32'h00000000);
      rst_n <= 1'b1;
      rd(`OFS_STATUS, rdat);
      chk_word(rdat, 32'h00000200);
      chk_byte(io_pins.oe, 8'h00);
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   initial begin
      do_reset;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rdat);
         chk_word(rdat, rows[i].exp);
      end
      // cell 0 registered, the rest inputs; one term taken from input 0
      wr(`OFS_CELL_CFG, 32'h0000FFFC);
      wr(`OFS_PT_INDEX, 32'h00000000);
      wr(`OFS_PT_DATA, 32'h00000001);
      board_model_i.set_in(8'h01, 8'h00, 1'b0);
      board_model_i.pulse_clock();
      rd(`OFS_STATUS, rdat);
      chk_word(rdat, 32'h00000001);
      chk_byte(io_pins.oe, 8'h01);
      chk_byte({7'h00, io_pins.level[0]}, 8'h00);
      board_model_i.set_in(8'h00, 8'hFF, 1'b1);
      repeat (3) @(posedge clk_sys);
      chk_byte(io_pins.oe, 8'h00);
      board_model_i.pulse_clock();
      chk_byte({7'h00, io_pins.level[0]}, 8'h01);
      wr(`OFS_PRELOAD, 32'h00000203);
      wr(`OFS_PRELOAD, 32'h00000101);
      rd(`OFS_STATUS, rdat);
      chk_word(rdat, 32'h00000003);
      // fuse goes last in a programming run; preload follows only to see it refused
      wr(`OFS_SECURE, 32'h00000001);
      wr(`OFS_PRELOAD, 32'h0000FF00);
      rd(`OFS_PT_DATA, rdat);
      chk_word(rdat, 32'h00000000);
      rd(`OFS_STATUS, rdat);
      chk_word(rdat, 32'h00000503);
      wr(`OFS_STATUS, 32'h00000400);
      wr(8'h2C, 32'h0000005A);
      rd(8'h2C, rdat);
      chk_word(rdat, 32'h0000005A);
      rd(`OFS_STATUS, rdat);
      chk_word(rdat, 32'h00000103);
      wr(`OFS_MODE, 32'h00000002);
      wr(`OFS_CELL_CFG, 32'h0000FFFF);
      repeat (3) @(posedge clk_sys);
      chk_byte(io_pins.oe, 8'h18);
      chk_byte(io_pins.level & 8'h18, 8'h00);
      wr(8'h24, 32'h000000C3);
      rd(8'h24, rdat);
      chk_word(rdat, 32'h000000C3);
      wr(`OFS_MODE, 32'h00000001);
      wr(`OFS_CELL_CFG, 32'h0000FFEF);
      repeat (3) @(posedge clk_sys);
      chk_byte(io_pins.oe, 8'h04);
      chk_byte({7'h00, io_pins.level[2]}, 8'h00);
      // cell 2 as I/O, its enable term true only while cell 6's pin reads low
      wr(`OFS_PT_INDEX, 32'h00000017);
      wr(`OFS_PT_DATA, 32'h40000000);
      wr(`OFS_CELL_CFG, 32'h0000FFDF);
      repeat (3) @(posedge clk_sys);
      chk_byte(io_pins.oe, 8'h00);
      board_model_i.set_io(8'h00, 8'h40);
      repeat (3) @(posedge clk_sys);
      chk_byte(io_pins.oe, 8'h04);
      do_reset;
      tally_and_finish;
   end
endmodule // testbench
